// File: mag_filter_pkg.sv
// Purpose: shared constants of the magnetometer and filter settings block
// Assumes: 32-bit register words, byte addresses
// Notes: command identifiers are the low byte of the command register
package mag_filter_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_ARG = 8'h40;
  localparam int ARG_WORDS = 9;
  localparam int ST_ACK = 0;
  localparam int ST_NACK = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // command identifiers
  // ---------------------------------------------------------------
  localparam logic [7:0] ID_WR_SPAN = 8'h21;
  localparam logic [7:0] ID_RD_SPAN = 8'h22;
  localparam logic [7:0] ID_WR_HARD = 8'h23;
  localparam logic [7:0] ID_RD_HARD = 8'h24;
  localparam logic [7:0] ID_WR_SOFT = 8'h25;
  localparam logic [7:0] ID_RD_SOFT = 8'h26;
  localparam logic [7:0] ID_WR_FIELD = 8'h27;
  localparam logic [7:0] ID_RD_FIELD = 8'h28;
  localparam logic [7:0] ID_WR_MODE = 8'h29;
  localparam logic [7:0] ID_RD_MODE = 8'h2a;
  localparam logic [7:0] ID_WR_PRESET = 8'h2b;
  localparam logic [7:0] ID_RD_PRESET = 8'h2c;
  localparam logic [7:0] ID_WR_SMOOTH = 8'h3c;
  localparam logic [7:0] ID_RD_SMOOTH = 8'h3d;
  localparam logic [7:0] ID_WR_MOTION = 8'h43;
  localparam logic [7:0] ID_RD_MOTION = 8'h44;
  localparam logic [7:0] ID_WR_TURN = 8'h45;
  localparam logic [7:0] ID_WR_SKEW = 8'h4c;
  localparam logic [7:0] ID_WR_BIAS = 8'h4d;
  localparam logic [7:0] ID_WR_REF = 8'h4e;
  localparam logic [7:0] ID_RD_SKEW = 8'h4f;
  localparam logic [7:0] ID_RD_BIAS = 8'h50;
  localparam logic [7:0] ID_RD_REF = 8'h51;

  // ---------------------------------------------------------------
  // setting codes, widths and reset values
  // ---------------------------------------------------------------
  localparam int SPAN_W = 10;
  localparam logic [31:0] SPAN_130 = 32'h0000_0082;
  localparam logic [31:0] SPAN_190 = 32'h0000_00be;
  localparam logic [31:0] SPAN_250 = 32'h0000_00fa;
  localparam logic [31:0] SPAN_400 = 32'h0000_0190;
  localparam logic [31:0] SPAN_470 = 32'h0000_01d6;
  localparam logic [31:0] SPAN_560 = 32'h0000_0230;
  localparam logic [31:0] SPAN_810 = 32'h0000_032a;
  localparam logic [2:0] MODE_MAX = 3'h4;
  localparam logic [1:0] PRESET_MAX = 2'h3;
  localparam logic [2:0] SMOOTH_MAX = 3'h5;
  localparam logic [2:0] MOTION_MAX = 3'h4;
  localparam logic [SPAN_W-1:0] RST_SPAN = 10'h082;
  localparam logic [2:0] RST_MODE = 3'h2;
  localparam logic [1:0] RST_PRESET = 2'h2;
  localparam logic [2:0] RST_SMOOTH = 3'h0;
  localparam logic [2:0] RST_MOTION = 3'h0;
  localparam logic RST_TURN = 1'b0;
  localparam logic [31:0] FLOAT_ONE = 32'h3f80_0000;

  // ---------------------------------------------------------------
  // calibration word store layout
  // ---------------------------------------------------------------
  localparam int VEC_WORDS = 28;
  localparam logic [4:0] HARD_BASE = 5'h00;
  localparam logic [4:0] SOFT_BASE = 5'h03;
  localparam logic [4:0] FIELD_BASE = 5'h0c;
  localparam logic [4:0] SKEW_BASE = 5'h0d;
  localparam logic [4:0] BIAS_BASE = 5'h16;
  localparam logic [4:0] REF_BASE = 5'h19;
  localparam logic [3:0] VEC3_LEN = 4'h3;
  localparam logic [3:0] MAT_LEN = 4'h9;
  localparam logic [3:0] ONE_LEN = 4'h1;

endpackage : mag_filter_pkg

// File: reg_if.sv
// Purpose: register access strobes between bus port and settings core
// Assumes: one access of each kind at a time
// Notes: rd_addr follows the read address channel directly
`timescale 1ns/1ps
interface reg_if #(parameter int AW = 8);
  logic wr_go;
  logic [AW-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_ok;
  logic [AW-1:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_ok;
  modport bus (output wr_go, wr_addr, wr_data, wr_strb, rd_addr,
    input wr_ok, rd_data, rd_ok);
  modport regs (input wr_go, wr_addr, wr_data, wr_strb, rd_addr,
    output wr_ok, rd_data, rd_ok);
endinterface : reg_if

// File: axil_port.sv
// Purpose: AXI4-Lite slave front end
// Assumes: ce stays high while a bus transfer is open
// Notes: address and data are taken in either order
`timescale 1ns/1ps
module axil_port
  import mag_filter_pkg::*;
#(parameter int AW = 8) (
  // clock, reset and enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // write channels
  input wire logic [AW-1:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  // read channels
  input wire logic [AW-1:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // core side
  reg_if.bus rif
);
  logic [AW-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;

  wire aw_take = s_awvalid && s_awready;
  wire w_take = s_wvalid && s_wready;
  wire b_done = s_bvalid && s_bready;
  wire ar_take = s_arvalid && s_arready;
  wire r_done = s_rvalid && s_rready;

  assign rif.wr_go = ce && !s_awready && !s_wready && !s_bvalid;
  assign rif.wr_addr = awaddr_q;
  assign rif.wr_data = wdata_q;
  assign rif.wr_strb = wstrb_q;
  assign rif.rd_addr = s_araddr;

  // -----------------------------------------------------------------
  // write path
  // -----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_awready <= 1'b1;
      s_wready <= 1'b1;
      s_bvalid <= 1'b0;
      s_bresp <= RESP_OKAY;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (ce) begin
      if (aw_take) begin
        s_awready <= 1'b0;
        awaddr_q <= s_awaddr;
      end
      if (w_take) begin
        s_wready <= 1'b0;
        wdata_q <= s_wdata;
        wstrb_q <= s_wstrb;
      end
      if (rif.wr_go) begin
        s_bvalid <= 1'b1;
        s_bresp <= rif.wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (b_done) begin
        s_bvalid <= 1'b0;
        s_awready <= 1'b1;
        s_wready <= 1'b1;
      end
    end
  end

  // -----------------------------------------------------------------
  // read path
  // -----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_arready <= 1'b1;
      s_rvalid <= 1'b0;
      s_rdata <= '0;
      s_rresp <= RESP_OKAY;
    end else if (ce) begin
      if (ar_take) begin
        s_arready <= 1'b0;
        s_rvalid <= 1'b1;
        s_rdata <= rif.rd_ok ? rif.rd_data : '0;
        s_rresp <= rif.rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (r_done) begin
        s_rvalid <= 1'b0;
        s_arready <= 1'b1;
      end
    end
  end
endmodule : axil_port

// File: code_check.sv
// Purpose: legality of the value carried by a settings write
// Assumes: value is the first argument word
// Notes: commands without a code list always pass
`timescale 1ns/1ps
module code_check
  import mag_filter_pkg::*;
(
  // command
  input wire logic [7:0] id,
  input wire logic [31:0] value,
  // verdict
  output logic ok
);
  wire span_ok = value == SPAN_130 || value == SPAN_190 ||
    value == SPAN_250 || value == SPAN_400 || value == SPAN_470 ||
    value == SPAN_560 || value == SPAN_810;
  assign ok =
    (id == ID_WR_SPAN) ? span_ok :
    (id == ID_WR_MODE) ? value <= 32'(MODE_MAX) :
    (id == ID_WR_PRESET) ? value <= 32'(PRESET_MAX) :
    (id == ID_WR_SMOOTH) ? value <= 32'(SMOOTH_MAX) :
    (id == ID_WR_MOTION) ? value <= 32'(MOTION_MAX) :
    (id == ID_WR_TURN) ? value <= 32'h0000_0001 : 1'b1;
endmodule : code_check

// File: mag_filter_settings_cmds.sv
// Purpose: magnetometer calibration and filter settings command handler
// Assumes: host stages argument words, then writes the command id
// Notes: answers land in the argument window and the status register
//
// Chosen here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
module mag_filter_settings_cmds
  import mag_filter_pkg::*;
#(parameter int AW = 8) (
  // clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // axi4-lite write
  input wire logic [AW-1:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  // axi4-lite read
  input wire logic [AW-1:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // current settings
  output logic [mag_filter_pkg::SPAN_W-1:0] field_sensor_span,
  output logic [2:0] filter_mode,
  output logic [1:0] filter_preset,
  output logic [2:0] raw_smoothing,
  output logic [2:0] motion_comp_level,
  output logic turning_comp_switch
);
  import mag_filter_pkg::*;

  if (AW < 7) begin : g_bad_aw
    $error("address width too small for the register map");
  end

  reg_if #(.AW(AW)) rif ();

  axil_port #(.AW(AW)) u_port (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid),
    .s_awready(s_awready),
    .s_wdata(s_wdata),
    .s_wstrb(s_wstrb),
    .s_wvalid(s_wvalid),
    .s_wready(s_wready),
    .s_bresp(s_bresp),
    .s_bvalid(s_bvalid),
    .s_bready(s_bready),
    .s_araddr(s_araddr),
    .s_arvalid(s_arvalid),
    .s_arready(s_arready),
    .s_rdata(s_rdata),
    .s_rresp(s_rresp),
    .s_rvalid(s_rvalid),
    .s_rready(s_rready),
    .rif(rif)
  );

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  logic [31:0] arg_q [ARG_WORDS];
  logic [31:0] resp_q [ARG_WORDS];
  logic [31:0] vec_q [VEC_WORDS];
  logic [SPAN_W-1:0] span_q;
  logic [2:0] mode_q;
  logic [1:0] preset_q;
  logic [2:0] smooth_q;
  logic [2:0] motion_q;
  logic turn_q;
  logic ack_q;
  logic nack_q;
  logic [7:0] last_id_q;

  // -----------------------------------------------------------------
  // address decode
  // -----------------------------------------------------------------
  wire [AW-1:0] wr_rel = rif.wr_addr - AW'(OFS_ARG);
  wire [AW-1:0] rd_rel = rif.rd_addr - AW'(OFS_ARG);
  wire wr_arg = wr_rel[1:0] == 2'h0 && wr_rel < AW'(ARG_WORDS * 4);
  wire rd_arg = rd_rel[1:0] == 2'h0 && rd_rel < AW'(ARG_WORDS * 4);
  wire wr_cmd = rif.wr_addr == AW'(OFS_CMD);
  wire wr_stat = rif.wr_addr == AW'(OFS_STATUS);
  wire rd_cmd = rif.rd_addr == AW'(OFS_CMD);
  wire rd_stat = rif.rd_addr == AW'(OFS_STATUS);
  wire [31:0] lane_mask = {{8{rif.wr_strb[3]}}, {8{rif.wr_strb[2]}},
    {8{rif.wr_strb[1]}}, {8{rif.wr_strb[0]}}};

  assign rif.wr_ok = wr_cmd || wr_stat || wr_arg;
  assign rif.rd_ok = rd_cmd || rd_stat || rd_arg;
  assign rif.rd_data = rd_cmd ? {24'h00_0000, last_id_q} :
    rd_stat ? {30'h0000_0000, nack_q, ack_q} :
    rd_arg ? resp_q[rd_rel[5:2]] : 32'h0000_0000;

  // -----------------------------------------------------------------
  // command decode
  // -----------------------------------------------------------------
  wire [7:0] id = rif.wr_data[7:0];
  // id byte only; a partial write without lane 0 is no command
  wire cmd_go = rif.wr_go && wr_cmd && rif.wr_strb[0];
  wire clr_go = rif.wr_go && wr_stat && rif.wr_strb[0];
  wire g_hard = id == ID_WR_HARD || id == ID_RD_HARD;
  wire g_soft = id == ID_WR_SOFT || id == ID_RD_SOFT;
  wire g_field = id == ID_WR_FIELD || id == ID_RD_FIELD;
  wire g_skew = id == ID_WR_SKEW || id == ID_RD_SKEW;
  wire g_bias = id == ID_WR_BIAS || id == ID_RD_BIAS;
  wire set_vec = id == ID_WR_HARD || id == ID_WR_SOFT ||
    id == ID_WR_FIELD || id == ID_WR_SKEW || id == ID_WR_BIAS ||
    id == ID_WR_REF;
  wire get_vec = id == ID_RD_HARD || id == ID_RD_SOFT ||
    id == ID_RD_FIELD || id == ID_RD_SKEW || id == ID_RD_BIAS ||
    id == ID_RD_REF;
  wire set_sc = id == ID_WR_SPAN || id == ID_WR_MODE ||
    id == ID_WR_PRESET || id == ID_WR_SMOOTH || id == ID_WR_MOTION ||
    id == ID_WR_TURN;
  wire get_sc = id == ID_RD_SPAN || id == ID_RD_MODE ||
    id == ID_RD_PRESET || id == ID_RD_SMOOTH || id == ID_RD_MOTION;
  wire [4:0] vec_base = g_hard ? HARD_BASE : g_soft ? SOFT_BASE :
    g_field ? FIELD_BASE : g_skew ? SKEW_BASE :
    g_bias ? BIAS_BASE : REF_BASE;
  wire [3:0] vec_len = (g_soft || g_skew) ? MAT_LEN :
    g_field ? ONE_LEN : VEC3_LEN;
  wire [3:0] get_len = get_vec ? vec_len : ONE_LEN;
  wire [31:0] scalar_word = (id == ID_RD_SPAN) ? 32'(span_q) :
    (id == ID_RD_MODE) ? 32'(mode_q) :
    (id == ID_RD_PRESET) ? 32'(preset_q) :
    (id == ID_RD_SMOOTH) ? 32'(smooth_q) :
    32'(motion_q);
  logic code_ok;

  code_check u_check (
    .id(id),
    .value(arg_q[0]),
    .ok(code_ok)
  );

  wire known = set_vec || get_vec || set_sc || get_sc;
  wire cmd_ok = known && code_ok;
  wire set_go = cmd_go && cmd_ok && set_sc;
  wire vec_go = cmd_go && set_vec;
  wire get_go = cmd_go && (get_vec || get_sc);

  // -----------------------------------------------------------------
  // argument words, byte lanes honoured
  // -----------------------------------------------------------------
  for (genvar i = 0; i < ARG_WORDS; i++) begin : g_arg
    wire hit = rif.wr_go && wr_arg && wr_rel[5:2] == 4'(i);
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        arg_q[i] <= 32'h0000_0000;
      end else if (hit) begin
        arg_q[i] <= (rif.wr_data & lane_mask) | (arg_q[i] & ~lane_mask);
      end
    end
  end

  // -----------------------------------------------------------------
  // calibration word store, matrices reset to identity
  // -----------------------------------------------------------------
  for (genvar k = 0; k < VEC_WORDS; k++) begin : g_vec
    localparam bit DIAG =
      (k >= SOFT_BASE && k < SOFT_BASE + 9 && (k - SOFT_BASE) % 4 == 0) ||
      (k >= SKEW_BASE && k < SKEW_BASE + 9 && (k - SKEW_BASE) % 4 == 0);
    localparam logic [31:0] RV = DIAG ? FLOAT_ONE : 32'h0000_0000;
    wire [4:0] rel = 5'(k) - vec_base;
    wire hit = vec_go && 5'(k) >= vec_base && rel < 5'(vec_len);
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        vec_q[k] <= RV;
      end else if (hit) begin
        vec_q[k] <= arg_q[rel[3:0]];
      end
    end
  end

  // -----------------------------------------------------------------
  // answer words; unused tail reads zero
  // -----------------------------------------------------------------
  for (genvar j = 0; j < ARG_WORDS; j++) begin : g_resp
    wire [4:0] src = vec_base + 5'(j);
    wire [31:0] word = (4'(j) >= get_len) ? 32'h0000_0000 :
      get_vec ? vec_q[src] :
      scalar_word;
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        resp_q[j] <= 32'h0000_0000;
      end else if (get_go) begin
        resp_q[j] <= word;
      end
    end
  end

  // -----------------------------------------------------------------
  // mode settings, only legal codes land
  // -----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      span_q <= RST_SPAN;
      mode_q <= RST_MODE;
      preset_q <= RST_PRESET;
      smooth_q <= RST_SMOOTH;
      motion_q <= RST_MOTION;
      turn_q <= RST_TURN;
    end else if (set_go) begin
      if (id == ID_WR_SPAN) span_q <= arg_q[0][SPAN_W-1:0];
      if (id == ID_WR_MODE) mode_q <= arg_q[0][2:0];
      if (id == ID_WR_PRESET) preset_q <= arg_q[0][1:0];
      if (id == ID_WR_SMOOTH) smooth_q <= arg_q[0][2:0];
      if (id == ID_WR_MOTION) motion_q <= arg_q[0][2:0];
      if (id == ID_WR_TURN) turn_q <= arg_q[0][0];
    end
  end

  assign field_sensor_span = span_q;
  assign filter_mode = mode_q;
  assign filter_preset = preset_q;
  assign raw_smoothing = smooth_q;
  assign motion_comp_level = motion_q;
  assign turning_comp_switch = turn_q;

  // -----------------------------------------------------------------
  // status: a new verdict beats a same-cycle clear
  // -----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ack_q <= 1'b0;
      nack_q <= 1'b0;
      last_id_q <= 8'h00;
    end else if (cmd_go) begin
      ack_q <= cmd_ok;
      nack_q <= !cmd_ok;
      last_id_q <= id;
    end else if (clr_go) begin
      ack_q <= ack_q && !rif.wr_data[ST_ACK];
      nack_q <= nack_q && !rif.wr_data[ST_NACK];
    end
  end

  // -----------------------------------------------------------------
  // assertions
  // -----------------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  wire span_legal = 32'(span_q) == SPAN_130 || 32'(span_q) == SPAN_190 ||
    32'(span_q) == SPAN_250 || 32'(span_q) == SPAN_400 ||
    32'(span_q) == SPAN_470 || 32'(span_q) == SPAN_560 ||
    32'(span_q) == SPAN_810;

  chk_ack_on_accept: assert property (
    cmd_go && cmd_ok |=> ack_q && !nack_q)
    else $error("accepted command without acknowledge");
  chk_span_legal: assert property (
    span_legal)
    else $error("stored span is not a listed value");
  chk_span_read: assert property (
    cmd_go && id == ID_RD_SPAN |=> resp_q[0] == 32'(span_q) &&
      resp_q[1] == 32'h0000_0000)
    else $error("span read answer wrong");
  chk_hard_store: assert property (
    cmd_go && id == ID_WR_HARD |=>
      vec_q[HARD_BASE + 2] == $past(arg_q[2]) &&
      vec_q[SOFT_BASE] == $past(vec_q[SOFT_BASE]))
    else $error("hard iron word not stored or neighbour disturbed");
  chk_soft_read: assert property (
    cmd_go && id == ID_RD_SOFT |=> resp_q[8] == vec_q[SOFT_BASE + 8])
    else $error("soft iron read answer wrong");
  chk_preset_read: assert property (
    cmd_go && id == ID_RD_PRESET |=> resp_q[0] == 32'(preset_q))
    else $error("preset read answer wrong");
  chk_mode_range: assert property (
    mode_q <= MODE_MAX && preset_q <= PRESET_MAX)
    else $error("filter mode or preset out of range");
  chk_motion_range: assert property (
    motion_q <= MOTION_MAX && smooth_q <= SMOOTH_MAX)
    else $error("compensation or smoothing code out of range");
  chk_bad_keeps: assert property (
    cmd_go && !cmd_ok |=> nack_q && !ack_q && $stable(span_q) &&
      $stable(mode_q) && $stable(motion_q) && $stable(turn_q))
    else $error("refused write changed a setting");
  chk_turn_store: assert property (
    cmd_go && cmd_ok && id == ID_WR_TURN |=> turn_q == $past(arg_q[0][0]))
    else $error("turning switch not stored");
  chk_field_read: assert property (
    cmd_go && id == ID_RD_FIELD |=> resp_q[0] == vec_q[FIELD_BASE] &&
      resp_q[1] == 32'h0000_0000)
    else $error("field estimate read answer wrong");
  chk_skew_read: assert property (
    cmd_go && id == ID_RD_SKEW |=> resp_q[0] == vec_q[SKEW_BASE] &&
      resp_q[8] == vec_q[SKEW_BASE + 8])
    else $error("skew matrix read answer wrong");
  chk_bias_store: assert property (
    cmd_go && id == ID_WR_BIAS |=>
      vec_q[BIAS_BASE] == $past(arg_q[0]) &&
      vec_q[REF_BASE] == $past(vec_q[REF_BASE]))
    else $error("skew bias not stored or neighbour disturbed");

  cov_accept: cover property (cmd_go && set_sc && cmd_ok ##1 ack_q);
  cov_refuse: cover property (cmd_go && set_sc && !cmd_ok);
  cov_matrix_get: cover property (cmd_go && id == ID_RD_SKEW);
  cov_span_refuse: cover property (cmd_go && id == ID_WR_SPAN && !cmd_ok);
  cov_vec_set: cover property (vec_go ##1 ack_q);
endmodule : mag_filter_settings_cmds

// File: axil_host.sv
// Purpose: host side of the settings register bus
// Assumes: one caller; each task starts on a rising edge
// Notes: released address and data lines show inverted values
`timescale 1ns/1ps
module axil_host (
  // clock
  input wire logic aclk,
  // write channels
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  // read channels
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  initial begin
    {awaddr, wdata, wstrb, araddr} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
  end
  // no fixed latency assumed: only the bench timeout ends a wait
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    {awvalid, wvalid, bready} <= 3'b111;
    do begin
      @(posedge aclk);
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        wdata <= ~d;
      end
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
    output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    do begin
      @(posedge aclk);
      if (arvalid && arready) begin
        arvalid <= 1'b0;
        araddr <= ~a;
      end
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd
endmodule : axil_host

// File: test_mag_filter_settings_cmds.sv
// Purpose: self-checking bench of the settings command handler
// Assumes: args staged before each command word
// Notes: status cleared after every command
`timescale 1ns/1ps
module test_mag_filter_settings_cmds;
  import mag_filter_pkg::*;
  logic aclk, aresetn, ce;
  logic [7:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, rv;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  logic [9:0] span;
  logic [2:0] mode, smooth, motion;
  logic [1:0] preset;
  logic turn;
  logic [11:0] outs;
  assign outs = {motion, smooth, 1'b0, preset, mode};
  int err_total, n_tests, cyc;
  logic [31:0] spans[7] = '{SPAN_130, SPAN_190, SPAN_250, SPAN_400,
    SPAN_470, SPAN_560, SPAN_810};
  logic [7:0] cw[5] = '{ID_WR_MODE, ID_WR_PRESET, ID_WR_SMOOTH,
    ID_WR_MOTION, ID_WR_TURN};
  logic [7:0] cr[5] = '{ID_RD_MODE, ID_RD_PRESET, ID_RD_SMOOTH,
    ID_RD_MOTION, 8'h00};
  int cmax[5] = '{4, 3, 5, 4, 1};
  logic [7:0] vw[6] = '{ID_WR_HARD, ID_WR_SOFT, ID_WR_FIELD, ID_WR_SKEW,
    ID_WR_BIAS, ID_WR_REF};
  logic [7:0] vr[6] = '{ID_RD_HARD, ID_RD_SOFT, ID_RD_FIELD, ID_RD_SKEW,
    ID_RD_BIAS, ID_RD_REF};
  int vn[6] = '{3, 9, 1, 9, 3, 3};
  mag_filter_settings_cmds #(.AW(8)) i_mag_filter_settings_cmds (.aclk,
    .aresetn, .ce, .s_awaddr(awaddr), .s_awvalid(awvalid),
    .s_awready(awready), .s_wdata(wdata), .s_wstrb(wstrb),
    .s_wvalid(wvalid), .s_wready(wready), .s_bresp(bresp),
    .s_bvalid(bvalid), .s_bready(bready), .s_araddr(araddr),
    .s_arvalid(arvalid), .s_arready(arready), .s_rdata(rdata),
    .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready),
    .field_sensor_span(span), .filter_mode(mode), .filter_preset(preset),
    .raw_smoothing(smooth), .motion_comp_level(motion),
    .turning_comp_switch(turn));
  axil_host i_axil_host (.aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready);
  initial aclk = 1'b0;
  always #12.5 aclk = ~aclk;
  // -------------------------------------------------------------
  // tasks
  // -------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] e,
    input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic put(input logic [7:0] a, input logic [31:0] d);
    i_axil_host.wr(a, d, resp);
    chk("bresp", 32'h0, {30'h0, resp});
  endtask : put
  task automatic take(input logic [7:0] a);
    i_axil_host.rd(a, rv, resp);
    chk("rresp", 32'h0, {30'h0, resp});
  endtask : take
  // command, then verdict in status, then clear
  task automatic run(input logic [7:0] id, input logic [31:0] st);
    put(OFS_CMD, {24'h0, id});
    take(OFS_STATUS);
    chk("status", st, rv);
    put(OFS_STATUS, 32'h0000_0003);
  endtask : run
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      complete_run();
    end
  end
  // -------------------------------------------------------------
  // sequence
  // -------------------------------------------------------------
  initial begin
    aresetn = 1'b0;
    ce = 1'b1;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (spans[k]) begin
      put(OFS_ARG, spans[k]);
      run(ID_WR_SPAN, 32'h0000_0001);
      run(ID_RD_SPAN, 32'h0000_0001);
      take(OFS_ARG);
      chk("span", spans[k], rv);
      chk("span_out", spans[k], {22'h0, span});
    end
    put(OFS_ARG, 32'h0000_0083);
    run(ID_WR_SPAN, 32'h0000_0002);
    chk("span_kept", SPAN_810, {22'h0, span});
    for (int k = 0; k < 5; k++) begin
      for (int v = 0; v <= cmax[k] + 1; v++) begin
        put(OFS_ARG, 32'(v));
        run(cw[k], (v > cmax[k]) ? 32'h2 : 32'h1);
        if (k == 4) begin
          chk("turn", (v > 1) ? 32'h1 : 32'(v), {31'h0, turn});
        end else begin
          run(cr[k], 32'h0000_0001);
          take(OFS_ARG);
          chk("code", 32'((v > cmax[k]) ? cmax[k] : v), rv);
          chk("code_out", 32'((v > cmax[k]) ? cmax[k] : v),
            32'(outs[3 * k +: 3]));
        end
      end
    end
    for (int k = 0; k < 6; k++) begin
      for (int i = 0; i < vn[k]; i++) begin
        put(OFS_ARG + 8'(4 * i), 32'h4000_0000 | 32'(k * 256 + i));
      end
      run(vw[k], 32'h0000_0001);
      run(vr[k], 32'h0000_0001);
      for (int i = 0; i < 9; i++) begin
        take(OFS_ARG + 8'(4 * i));
        chk("vec", (i < vn[k]) ? 32'h4000_0000 | 32'(k * 256 + i) : 0,
          rv);
      end
    end
    run(8'h01, 32'h0000_0002);
    take(OFS_CMD);
    chk("last_id", 32'h0000_0001, rv);
    i_axil_host.wr(8'h80, 32'h1234_5678, resp);
    chk("bresp_bad", {30'h0, RESP_SLVERR}, {30'h0, resp});
    i_axil_host.rd(8'h80, rv, resp);
    chk("rresp_bad", {30'h0, RESP_SLVERR}, {30'h0, resp});
    chk("rdata_bad", 32'h0, rv);
    complete_run();
  end
endmodule : test_mag_filter_settings_cmds
